// [core/spwm_top.sv]
// standard single-output pwm generator with selectable period timers
// Functional notes
// - Waveform appears on one output pin with up to 10-bit duty resolution.
// - Writing zero to the control register releases the pin and clears its latch.
// - Period comes from one of three 8-bit timers, chosen by a 2-bit field.
// - Period equals (period value + 1) x 4 clocks x prescale ratio.
// - Timer clears to zero on the step after it equals the period value.
// - Pin goes high at each period start unless the new duty is zero.
// - Each period start copies the writable duty into the shadow duty.
// - The timer postscaler has no effect on the waveform period.
// - Duty is upper byte as 8 MSBs plus control bits 5:4 as LSBs.
// - Duty writes are accepted anytime but act only from the next period.
// - In pwm mode the shadow duty register ignores software writes.
// - High time equals the 10-bit duty x one clock x prescale ratio.
// - Time base is the 8-bit timer extended by two clock or prescaler bits.
// - Pin goes low when the time base equals the 10-bit shadow duty.
// - A duty beyond the period leaves the pin high for the whole period.
// - Sleep freezes timers and state while the pin keeps its level.
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
module spwm_top import spwm_pkg::*; #(
   parameter int N_TIMERS = 3
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // wishbone register bus
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // power state
   input wire logic i_sleep,
   // output pin
   output logic o_pwm_out,
   output logic o_pwm_oe
);
   if (N_TIMERS < 1 || N_TIMERS > 4) begin : g_bad_timers
      $error("N_TIMERS must lie in 1..4 for a 2-bit select");
   end

   // register state
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] duty_upper_q;
   logic [7:0] duty_upper_d;
   logic [7:0] shadow_q;
   logic [7:0] shadow_d;
   logic [1:0] shadow_low_q;
   logic [1:0] shadow_low_d;
   logic [1:0] tsel_q;
   logic [1:0] tsel_d;
   logic [N_TIMERS-1:0] flag_q;
   logic [N_TIMERS-1:0] flag_d;
   logic pin_dir_q;
   logic pin_dir_d;
   logic pin_q;
   logic pin_d;
   logic start_q;
   logic start_d;
   logic [7:0] period_q [N_TIMERS];
   logic [7:0] period_d [N_TIMERS];
   logic [TCTRL_W-1:0] tctl_q [N_TIMERS];
   logic [TCTRL_W-1:0] tctl_d [N_TIMERS];

   // timer outputs
   logic [7:0] t_count [N_TIMERS];
   logic [1:0] t_low [N_TIMERS];
   logic [N_TIMERS-1:0] t_end;

   // bus side
   logic [5:0] idx;
   logic [7:0] wdata;
   logic wr;
   logic [31:0] rdata;

   // datapath
   logic pwm_mode;
   logic [1:0] sel;
   logic [9:0] time_base;
   logic [9:0] duty_next;
   logic [9:0] duty_live;
   logic boundary;
   logic [3:0] tnum;
   logic in_timer;

   spwm_wb_slave u_bus (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb),
      .i_wb_we(i_wb_we),
      .i_wb_adr(i_wb_adr),
      .i_wb_sel(i_wb_sel),
      .i_wb_dat(i_wb_dat),
      .o_wb_dat(o_wb_dat),
      .o_wb_ack(o_wb_ack),
      .i_rdata(rdata),
      .o_idx(idx),
      .o_wdata(wdata),
      .o_wr(wr)
   );

   // postscale bits sit in tctl_q[6:3] and are never looked at here
   for (genvar n = 0; n < N_TIMERS; n++) begin : g_timer
      spwm_timer u_timer (
         .i_clock(i_clock),
         .i_reset(i_reset),
         .i_freeze(i_sleep),
         .i_on(tctl_q[n][TCTRL_ON_BIT]),
         .i_prescale(tctl_q[n][TCTRL_PS_MSB:TCTRL_PS_LSB]),
         .i_period(period_q[n]),
         .o_count(t_count[n]),
         .o_low(t_low[n]),
         .o_tick(),
         .o_period_end(t_end[n])
      );
   end

   // selection and compare datapath
   always_comb begin
      pwm_mode = (ctrl_q[CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_PWM);
      // an unbuilt timer code falls back to timer 0
      sel = (32'(tsel_q) < N_TIMERS) ? tsel_q : 2'h0;
      time_base = {t_count[sel], t_low[sel]};
      duty_next = {duty_upper_q, ctrl_q[CTRL_DLOW_MSB:CTRL_DLOW_LSB]};
      duty_live = {shadow_q, shadow_low_q};
      boundary = pwm_mode & t_end[sel];
      tnum = idx[5:2] - TIMER_BASE_WORD;
      in_timer = (idx >= IDX_TIMER_BASE) && (32'(tnum) < N_TIMERS) && (idx[1:0] <= SUB_COUNT);
   end

   // register writes, flags and pin latch
   always_comb begin
      ctrl_d = ctrl_q;
      duty_upper_d = duty_upper_q;
      shadow_d = shadow_q;
      shadow_low_d = shadow_low_q;
      tsel_d = tsel_q;
      pin_dir_d = pin_dir_q;
      period_d = period_q;
      tctl_d = tctl_q;
      // a match in the same cycle as a clear keeps the flag set
      flag_d = flag_q | t_end;
      if (wr) begin
         unique case (idx)
            IDX_CONTROL: ctrl_d = wdata;
            IDX_DUTY_UPPER: duty_upper_d = wdata;
            IDX_DUTY_SHADOW: begin
               if (!pwm_mode) begin
                  shadow_d = wdata;
               end
            end
            IDX_TIMER_SEL: tsel_d = wdata[1:0];
            IDX_FLAGS: flag_d = (flag_q & ~wdata[N_TIMERS-1:0]) | t_end;
            IDX_PIN_DIR: pin_dir_d = wdata[0];
            default: begin
               if (in_timer) begin
                  for (int n = 0; n < N_TIMERS; n++) begin
                     if (32'(tnum) == n && idx[1:0] == SUB_PERIOD) begin
                        period_d[n] = wdata;
                     end
                     if (32'(tnum) == n && idx[1:0] == SUB_TCTRL) begin
                        tctl_d[n] = wdata[TCTRL_W-1:0];
                     end
                  end
               end
            end
         endcase
      end
      // the writable duty reaches the compare only at a period start
      if (boundary) begin
         shadow_d = duty_next[9:2];
         shadow_low_d = duty_next[1:0];
      end
      // the pin rises one clock after the boundary: with a registered pin
      // this keeps a duty of n high for exactly n time-base steps
      // a start still pending when sleep begins waits for wake-up
      start_d = i_sleep ? start_q : boundary;
      pin_d = pin_q;
      if (ctrl_q == RST_BYTE) begin
         pin_d = 1'b0;
      end else if (pwm_mode && !i_sleep) begin
         if (start_q) begin
            pin_d = (duty_live != 10'h000);
         end else if (time_base == duty_live) begin
            // a duty past the period never matches, so the pin stays high
            pin_d = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         ctrl_q <= RST_BYTE;
         duty_upper_q <= RST_BYTE;
         shadow_q <= RST_BYTE;
         shadow_low_q <= 2'h0;
         tsel_q <= RST_TSEL;
         flag_q <= '0;
         pin_dir_q <= RST_PIN_DIR;
         pin_q <= 1'b0;
         start_q <= 1'b0;
         for (int n = 0; n < N_TIMERS; n++) begin
            period_q[n] <= RST_BYTE;
            tctl_q[n] <= '0;
         end
      end else begin
         ctrl_q <= ctrl_d;
         duty_upper_q <= duty_upper_d;
         shadow_q <= shadow_d;
         shadow_low_q <= shadow_low_d;
         tsel_q <= tsel_d;
         flag_q <= flag_d;
         pin_dir_q <= pin_dir_d;
         pin_q <= pin_d;
         start_q <= start_d;
         period_q <= period_d;
         tctl_q <= tctl_d;
      end
   end

   // read mux; unmapped words and bits above each register's width read zero
   always_comb begin
      rdata = 32'h00000000;
      unique case (idx)
         IDX_CONTROL: rdata[7:0] = ctrl_q;
         IDX_DUTY_UPPER: rdata[7:0] = duty_upper_q;
         IDX_DUTY_SHADOW: rdata[7:0] = shadow_q;
         IDX_TIMER_SEL: rdata[1:0] = tsel_q;
         IDX_FLAGS: rdata[N_TIMERS-1:0] = flag_q;
         IDX_PIN_DIR: rdata[0] = pin_dir_q;
         default: begin
            if (in_timer) begin
               for (int n = 0; n < N_TIMERS; n++) begin
                  if (32'(tnum) == n) begin
                     unique case (idx[1:0])
                        SUB_PERIOD: rdata[7:0] = period_q[n];
                        SUB_TCTRL: rdata[TCTRL_W-1:0] = tctl_q[n];
                        default: rdata[7:0] = t_count[n];
                     endcase
                  end
               end
            end
         end
      endcase
   end

   // pin is driven only in pwm mode with the direction bit cleared
   assign o_pwm_oe = pwm_mode & ~pin_dir_q;
   assign o_pwm_out = pin_q;

   chk_pin_release: assert property (@(posedge i_clock) disable iff (i_reset)
      (ctrl_q == 8'h00) |-> (!o_pwm_oe ##1 !o_pwm_out))
      else $error("pin still driven with control cleared");
   chk_pin_set: assert property (@(posedge i_clock) disable iff (i_reset)
      (start_q && pwm_mode && !i_sleep && duty_live != 10'h000) |=> o_pwm_out)
      else $error("pin not set at period start");
   chk_zero_duty: assert property (@(posedge i_clock) disable iff (i_reset)
      (start_q && pwm_mode && !i_sleep && duty_live == 10'h000) |=> !o_pwm_out)
      else $error("pin set with zero duty");
   chk_shadow_load: assert property (@(posedge i_clock) disable iff (i_reset)
      boundary |=> (duty_live == $past(duty_next)))
      else $error("shadow duty not loaded at period start");
   chk_shadow_ro: assert property (@(posedge i_clock) disable iff (i_reset)
      (pwm_mode && !boundary) |=> $stable(duty_live))
      else $error("shadow duty changed inside a period");
   chk_match_clear: assert property (@(posedge i_clock) disable iff (i_reset)
      (pwm_mode && !i_sleep && !start_q && ctrl_q != 8'h00 && time_base == duty_live) |=> !o_pwm_out)
      else $error("pin not cleared at duty match");
   chk_sleep_freeze: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_sleep && ctrl_q != 8'h00) |=> ($stable(o_pwm_out) && $stable(time_base)))
      else $error("state moved during sleep");
   chk_period_wrap: assert property (@(posedge i_clock) disable iff (i_reset)
      t_end[sel] |=> (t_count[$past(sel)] == 8'h00))
      else $error("selected timer not cleared at period end");
   chk_upper_write: assert property (@(posedge i_clock) disable iff (i_reset)
      (wr && idx == IDX_DUTY_UPPER && !boundary) |=> (duty_upper_q == $past(wdata) && $stable(duty_live)))
      else $error("duty write reached the compare early");
   // pin timing between period start and duty match
   chk_pin_hold: assert property (@(posedge i_clock) disable iff (i_reset)
      (pwm_mode && !i_sleep && !start_q && time_base != duty_live) |=> $stable(o_pwm_out))
      else $error("pin moved away from period start and duty match");
   chk_sleep_start: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_sleep && start_q) |=> start_q)
      else $error("pending period start lost in sleep");
   chk_oe_gate: assert property (@(posedge i_clock) disable iff (i_reset)
      (pin_dir_q || !pwm_mode) |-> !o_pwm_oe)
      else $error("pin driven while direction is input or mode is off");
   chk_low_pair: assert property (@(posedge i_clock) disable iff (i_reset)
      boundary |=> (shadow_low_q == $past(ctrl_q[CTRL_DLOW_MSB:CTRL_DLOW_LSB])))
      else $error("duty low bits not taken from control");
   chk_shadow_write: assert property (@(posedge i_clock) disable iff (i_reset)
      (wr && idx == IDX_DUTY_SHADOW && !pwm_mode) |=> (shadow_q == $past(wdata)))
      else $error("shadow duty write lost outside pwm mode");
   // reset itself is the antecedent, so no disable here
   chk_reset_state: assert property (@(posedge i_clock)
      $past(i_reset) |-> (!o_pwm_out && !o_pwm_oe && duty_live == 10'h000 && duty_upper_q == 8'h00))
      else $error("state not cleared by reset");
endmodule // spwm_top

// [core/spwm_pkg.sv]
// register map, field layout and timing constants of the standard modulator
package spwm_pkg;
   // register word indices; byte address is four times the index
   localparam logic [5:0] IDX_CONTROL = 6'h00;
   localparam logic [5:0] IDX_DUTY_UPPER = 6'h01;
   localparam logic [5:0] IDX_DUTY_SHADOW = 6'h02;
   localparam logic [5:0] IDX_TIMER_SEL = 6'h03;
   localparam logic [5:0] IDX_FLAGS = 6'h04;
   localparam logic [5:0] IDX_PIN_DIR = 6'h05;
   // timer n owns indices IDX_TIMER_BASE + 4*n + sub-index
   localparam logic [5:0] IDX_TIMER_BASE = 6'h08;
   localparam logic [3:0] TIMER_BASE_WORD = 4'h2;
   localparam logic [1:0] SUB_PERIOD = 2'h0;
   localparam logic [1:0] SUB_TCTRL = 2'h1;
   localparam logic [1:0] SUB_COUNT = 2'h2;
   // pwm_control fields
   localparam int CTRL_MODE_MSB = 3;
   localparam int CTRL_MODE_LSB = 2;
   localparam logic [1:0] MODE_PWM = 2'h3;
   localparam int CTRL_DLOW_MSB = 5;
   localparam int CTRL_DLOW_LSB = 4;
   // timer_control fields
   localparam int TCTRL_ON_BIT = 2;
   localparam int TCTRL_PS_MSB = 1;
   localparam int TCTRL_PS_LSB = 0;
   localparam int TCTRL_W = 7;
   // prescale_select codes and last prescaler count per timer step
   localparam logic [1:0] PS_1 = 2'h0;
   localparam logic [1:0] PS_4 = 2'h1;
   localparam logic [5:0] PRE_LIMIT_1 = 6'h03;
   localparam logic [5:0] PRE_LIMIT_4 = 6'h0F;
   localparam logic [5:0] PRE_LIMIT_16 = 6'h3F;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic RST_PIN_DIR = 1'b1;
   localparam logic [1:0] RST_TSEL = 2'h0;
endpackage

// [core/spwm_timer.sv]
// 8-bit period timer with prescaler and 2-bit fine time base
`timescale 1ns/100ps
module spwm_timer import spwm_pkg::*; (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // control
   input wire logic i_freeze,
   input wire logic i_on,
   input wire logic [1:0] i_prescale,
   input wire logic [7:0] i_period,
   // state
   output logic [7:0] o_count,
   output logic [1:0] o_low,
   output logic o_tick,
   output logic o_period_end
);
   logic [5:0] pre_q;
   logic [5:0] pre_d;
   logic [5:0] limit;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic run;

   always_comb begin
      unique case (i_prescale)
         PS_1: begin
            limit = PRE_LIMIT_1;
            o_low = pre_q[1:0];
         end
         PS_4: begin
            limit = PRE_LIMIT_4;
            o_low = pre_q[3:2];
         end
         default: begin
            limit = PRE_LIMIT_16;
            o_low = pre_q[5:4];
         end
      endcase
      run = i_on & ~i_freeze;
      // >= so a prescale lowered mid-step cannot strand the counter
      o_tick = run & (pre_q >= limit);
      o_period_end = o_tick & (cnt_q == i_period);
      pre_d = pre_q;
      cnt_d = cnt_q;
      if (o_tick) begin
         pre_d = 6'h00;
         cnt_d = (cnt_q == i_period) ? 8'h00 : cnt_q + 8'h01;
      end else if (run) begin
         pre_d = pre_q + 6'h01;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         pre_q <= 6'h00;
         cnt_q <= 8'h00;
      end else begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
      end
   end

   assign o_count = cnt_q;

   chk_step_of_four: assert property (@(posedge i_clock) disable iff (i_reset)
      (o_tick && i_prescale == PS_1) |=> !o_tick [*3])
      else $error("timer stepped sooner than four clocks");
   chk_timer_wrap: assert property (@(posedge i_clock) disable iff (i_reset)
      o_period_end |=> (o_count == 8'h00))
      else $error("timer not cleared after period match");
   chk_count_holds: assert property (@(posedge i_clock) disable iff (i_reset)
      !o_tick |=> $stable(o_count))
      else $error("timer moved without a step");
endmodule // spwm_timer

// [core/spwm_wb_slave.sv]
// classic wishbone slave front end: one wait state, registered read data
`timescale 1ns/100ps
module spwm_wb_slave (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // wishbone
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // register file side
   input wire logic [31:0] i_rdata,
   output logic [5:0] o_idx,
   output logic [7:0] o_wdata,
   output logic o_wr
);
   logic ack_q;
   logic ack_d;
   logic [31:0] dat_q;
   logic [31:0] dat_d;
   logic req;

   always_comb begin
      req = i_wb_cyc & i_wb_stb;
      ack_d = req & ~ack_q;
      dat_d = dat_q;
      if (req && !ack_q) begin
         dat_d = i_rdata;
      end
      // write lands on the edge where the master sees ack
      o_wr = req & i_wb_we & ack_q & i_wb_sel[0];
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   assign o_idx = i_wb_adr[7:2];
   assign o_wdata = i_wb_dat[7:0];
   assign o_wb_ack = ack_q;
   assign o_wb_dat = dat_q;
endmodule // spwm_wb_slave

// [sim/spwm_load.sv]
// load on the pwm pin: measures rise-to-rise period and high time
`timescale 1ns/100ps
module spwm_load (
   // clock
   input wire logic i_clock,
   // pin
   input wire logic i_pin,
   input wire logic i_oe,
   // measurements of the last completed period, and the running count of rises
   output int o_high,
   output int o_period,
   output int o_rises
);
   logic lvl_q = 1'b0;
   int run_hi = 0;
   int run_all = 0;
   // pull-down on the pin, so a released pin reads low
   wire logic lvl = i_oe ? i_pin : 1'b0;
   initial begin
      o_high = 0;
      o_period = 0;
      o_rises = 0;
   end
   always @(posedge i_clock) begin
      lvl_q <= lvl;
      if (lvl && !lvl_q) begin
         o_period <= run_all;
         o_high <= run_hi;
         o_rises <= o_rises + 1;
         run_all <= 1;
         run_hi <= 1;
      end else begin
         run_all <= run_all + 1;
         run_hi <= run_hi + (lvl ? 1 : 0);
      end
   end
endmodule // spwm_load

// [sim/tb_standard_pwm_generator.sv]
// register-level testbench of the standard pwm generator
`timescale 1ns/100ps
module tb_standard_pwm_generator import spwm_pkg::*; ();
   localparam logic [5:0] T1 = IDX_TIMER_BASE + 6'h04;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic i_sleep = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h1;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic pout;
   logic poe;
   logic [7:0] q;
   logic [7:0] q2;
   logic lvl;
   int n_fail = 0;
   int checks_done = 0;
   int hi;
   int per;
   int rises;
   always #25 i_clock = ~i_clock;
   spwm_top uut (.i_clock(i_clock), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_sleep(i_sleep), .o_pwm_out(pout), .o_pwm_oe(poe));
   spwm_load load (.i_clock(i_clock), .i_pin(pout), .i_oe(poe), .o_high(hi), .o_period(per), .o_rises(rises));
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   // one classic cycle; waits for ack, data taken at the ack edge
   task bus(input logic w, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] r);
      int t;
      t = 0;
      @(posedge i_clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      do begin
         @(posedge i_clock);
         t++;
      end while (ack !== 1'b1 && t < 50);
      check("bus_ack", {31'h0, ack}, 32'h1);
      r = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task wr(input logic [5:0] idx, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, idx, d, r);
   endtask
   task rdc(input string name, input logic [5:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      bus(1'b0, idx, 8'h00, r);
      check(name, {24'h0, r}, {24'h0, exp});
   endtask
   task wait_rises(input int n);
      int r0;
      int t;
      r0 = rises;
      t = 0;
      while (rises < r0 + n && t < 3000) begin
         @(posedge i_clock);
         t++;
      end
      check("rises", {31'h0, rises >= r0 + n}, 32'h1);
   endtask
   // counts high cycles of the pin over n cycles
   task sample_high(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge i_clock);
         c += (pout === 1'b1) ? 1 : 0;
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #(20000 * 50);
      n_fail++;
      finish_test;
   end
   initial begin
      int c;
      int t;
      repeat (2) @(posedge i_clock);
      i_reset <= 1'b0;
      @(posedge i_clock);
      check("pin_reset", {30'h0, poe, pout}, 32'h0);
      rdc("ctrl_rst", IDX_CONTROL, RST_BYTE);
      rdc("duty_rst", IDX_DUTY_UPPER, RST_BYTE);
      rdc("shadow_rst", IDX_DUTY_SHADOW, RST_BYTE);
      rdc("pindir_rst", IDX_PIN_DIR, 8'h01);
      rdc("unmapped", 6'h3F, 8'h00);
      wr(IDX_DUTY_SHADOW, 8'h5A);
      rdc("shadow_free", IDX_DUTY_SHADOW, 8'h5A);
      $display("test reset done");
      // setup order: pin off, period, mode+low bits, duty, timer select, flag, timer on, pin on
      wr(IDX_PIN_DIR, 8'h01);
      wr(T1 + 6'h00, 8'h03);
      wr(IDX_CONTROL, 8'h2C);
      wr(IDX_DUTY_UPPER, 8'h01);
      wr(IDX_TIMER_SEL, 8'h01);
      wr(IDX_FLAGS, 8'h02);
      wr(T1 + 6'h01, 8'h04);
      t = 0;
      do begin
         bus(1'b0, IDX_FLAGS, 8'h00, q);
         t++;
      end while (q[1] !== 1'b1 && t < 100);
      check("flag_seen", {31'h0, q[1]}, 32'h1);
      check("poe_off", {31'h0, poe}, 32'h0);
      wr(IDX_PIN_DIR, 8'h00);
      wait_rises(3); // first pulse may be truncated, so it is skipped
      check("poe_on", {31'h0, poe}, 32'h1);
      check("period_ps1", per, 16);
      check("high_ps1", hi, 6);
      $display("test setup done");
      // prescale 4 with every postscale bit set
      wr(T1 + 6'h01, 8'h7D);
      wait_rises(3);
      check("period_ps4", per, 64);
      check("high_ps4", hi, 24);
      wait_rises(1);
      wr(IDX_DUTY_UPPER, 8'h03);
      wr(IDX_DUTY_SHADOW, 8'hAA);
      rdc("shadow_hold", IDX_DUTY_SHADOW, 8'h01);
      wait_rises(1);
      check("high_old", hi, 24);
      wait_rises(2);
      rdc("shadow_new", IDX_DUTY_SHADOW, 8'h03);
      check("high_new", hi, 56);
      $display("test double buffer done");
      // sleep freezes the count and the pin level
      @(posedge i_clock);
      i_sleep <= 1'b1;
      bus(1'b0, T1 + 6'h02, 8'h00, q);
      lvl = pout;
      repeat (20) @(posedge i_clock);
      bus(1'b0, T1 + 6'h02, 8'h00, q2);
      check("sleep_count", {24'h0, q2}, {24'h0, q});
      check("sleep_pin", {31'h0, pout}, {31'h0, lvl});
      i_sleep <= 1'b0;
      $display("test sleep done");
      // back to prescale 1: zero duty, then duty beyond the period
      wr(T1 + 6'h01, 8'h04);
      wr(IDX_DUTY_UPPER, 8'h00);
      wr(IDX_CONTROL, 8'h0C);
      repeat (140) @(posedge i_clock);
      sample_high(48, c);
      check("zero_duty", c, 0);
      wr(IDX_DUTY_UPPER, 8'hFF);
      repeat (40) @(posedge i_clock);
      sample_high(48, c);
      check("over_duty", c, 48);
      $display("test duty limits done");
      wr(IDX_CONTROL, 8'h00);
      repeat (2) @(posedge i_clock);
      check("release", {30'h0, poe, pout}, 32'h0);
      $display("test release done");
      finish_test;
   end
endmodule // tb_standard_pwm_generator
